//--- verilog/csl_pkg.sv
/*
  csl_pkg: shared constants, state type and helper function for the clock
  synthesizer, lock and reset block.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`default_nettype none

package csl_pkg;

    // register byte addresses
    localparam logic [7:0] CSL_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CSL_STATUS_ADDR = 8'h04;

    // control field positions
    localparam int CSL_MULT_LSB = 0;
    localparam int CSL_DIV_LSB = 8;
    localparam int CSL_FLD_W = 6;
    localparam int CSL_HALVE_BIT = 16;
    localparam int CSL_FB1X_BIT = 17;
    localparam int CSL_GCLK_BIT = 18;
    localparam int CSL_SOFT_RST_BIT = 24;

    // status field positions
    localparam int CSL_LOCKED_BIT = 0;
    localparam int CSL_IN_RST_BIT = 1;
    localparam int CSL_PVALID_BIT = 2;
    localparam int CSL_PERIOD_LSB = 16;

    // control reset value: multiplier 4, divisor 1, feedback single rate,
    // global input buffer, no halving, soft reset off
    localparam logic [31:0] CSL_CTRL_RST = 32'h0006_0104;
    localparam logic [31:0] CSL_CTRL_MASK = 32'h0107_3F3F;

    // legal setting ranges
    localparam logic [5:0] CSL_MULT_MIN = 6'h02;
    localparam logic [5:0] CSL_MULT_MAX = 6'h20;
    localparam logic [5:0] CSL_DIV_MIN = 6'h01;
    localparam logic [5:0] CSL_DIV_MAX = 6'h20;

    // widths
    localparam int CSL_PERIOD_W = 16;
    localparam int CSL_ACC_W = 24;

    // timing counts in system clock cycles; the lock count is in input periods
    localparam logic [15:0] CSL_SYNC_LAT = 16'h0003;
    localparam logic [15:0] CSL_FB_TOL = 16'h0002;
    localparam logic [15:0] CSL_PERIOD_TOL = 16'h0001;
    localparam logic [15:0] CSL_CNT_MAX = 16'hFFFF;
    localparam logic [2:0] CSL_LOCK_PERIODS = 3'h4;

    typedef enum logic [1:0] {
        CSL_ST_RESET,
        CSL_ST_WAIT,
        CSL_ST_MEAS,
        CSL_ST_RUN
    } csl_state_t;

    function automatic logic [5:0] csl_clamp(
        input logic [5:0] v,
        input logic [5:0] lo,
        input logic [5:0] hi
    );
        logic [5:0] r;
        r = v;
        if (v < lo)
        begin
            r = lo;
        end
        else if (v > hi)
        begin
            r = hi;
        end
        return r;
    endfunction : csl_clamp

endpackage : csl_pkg

`default_nettype wire

//--- verilog/csl_sync2.sv
/*
  csl_sync2: two flip-flop synchronizer for one level.
  Assumes d may change at any time relative to clk; only q is read outside.
*/
`timescale 1ns/1ns
`default_nettype none

module csl_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : csl_sync2

`default_nettype wire

//--- verilog/csl_clock_synth_lock_reset.sv
/*
  csl_clock_synth_lock_reset: digital clock manager slice. Rebuilds the base
  clock from the sampled source clock, synthesizes M/D times its effective
  frequency with an inverted twin, checks feedback alignment and raises lock.
  Assumes clk_sys is well above 4x the source clock and the synthesized
  clock stays below half of clk_sys; registers sit on classic Wishbone.
*/
`timescale 1ns/1ns
`default_nettype none

module csl_clock_synth_lock_reset (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic source_clk_in,
    input wire logic feedback_clk_in,
    input wire logic manager_reset_in,
    input wire logic global_set_reset,
    output logic synth_clk_out,
    output logic synth_clk_inv_out,
    output logic base_clk_out,
    output logic locked_out
);

    logic rst_n;
    logic src_s;
    logic fb_s;
    logic rst_pin_s;
    logic gsr_s;

    csl_sync2 u_rst_sync (.clk(clk_sys), .rst_n(arst_n), .d(1'b1), .q(rst_n));
    csl_sync2 u_src_sync (.clk(clk_sys), .rst_n(rst_n), .d(source_clk_in), .q(src_s));
    csl_sync2 u_fb_sync (.clk(clk_sys), .rst_n(rst_n), .d(feedback_clk_in), .q(fb_s));
    csl_sync2 u_rpin_sync (.clk(clk_sys), .rst_n(rst_n), .d(manager_reset_in), .q(rst_pin_s));
    csl_sync2 u_gsr_sync (.clk(clk_sys), .rst_n(rst_n), .d(global_set_reset), .q(gsr_s));

    // register bus
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;
    logic [31:0] status_word;
    logic wb_hit;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        for (int i = 0; i < 4; i++)
        begin
            if (wb_sel_i[i])
            begin
                ctrl_next[8*i +: 8] = wb_dat_i[8*i +: 8];
            end
        end
        ctrl_next = ctrl_next & csl_pkg::CSL_CTRL_MASK;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= wb_hit;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= csl_pkg::CSL_CTRL_RST;
        end
        else if (wb_hit && wb_we_i && wb_adr_i == csl_pkg::CSL_CTRL_ADDR)
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dat_reg <= 32'h0000_0000;
        end
        else if (wb_hit && !wb_we_i)
        begin
            // unmapped addresses read as zero but are still acknowledged
            unique case (wb_adr_i)
                csl_pkg::CSL_CTRL_ADDR: dat_reg <= ctrl_reg;
                csl_pkg::CSL_STATUS_ADDR: dat_reg <= status_word;
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // manager reset: pin, global set/reset and soft bit
    logic mgr_rst_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mgr_rst_reg <= 1'b1;
        end
        else
        begin
            mgr_rst_reg <= rst_pin_s | gsr_s | ctrl_reg[csl_pkg::CSL_SOFT_RST_BIT];
        end
    end

    // settings are captured only while held in reset, so a change takes effect
    // at the next reset release
    logic [5:0] act_mult_reg;
    logic [5:0] act_div_reg;
    logic act_half_reg;
    logic act_fb_reg;
    logic act_gclk_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_mult_reg <= csl_pkg::CSL_MULT_MIN;
            act_div_reg <= csl_pkg::CSL_DIV_MIN;
            act_half_reg <= 1'b0;
            act_fb_reg <= 1'b0;
            act_gclk_reg <= 1'b0;
        end
        else if (mgr_rst_reg)
        begin
            act_mult_reg <= csl_pkg::csl_clamp(
                ctrl_reg[csl_pkg::CSL_MULT_LSB +: csl_pkg::CSL_FLD_W],
                csl_pkg::CSL_MULT_MIN, csl_pkg::CSL_MULT_MAX);
            act_div_reg <= csl_pkg::csl_clamp(
                ctrl_reg[csl_pkg::CSL_DIV_LSB +: csl_pkg::CSL_FLD_W],
                csl_pkg::CSL_DIV_MIN, csl_pkg::CSL_DIV_MAX);
            act_half_reg <= ctrl_reg[csl_pkg::CSL_HALVE_BIT];
            act_fb_reg <= ctrl_reg[csl_pkg::CSL_FB1X_BIT];
            act_gclk_reg <= ctrl_reg[csl_pkg::CSL_GCLK_BIT];
        end
    end

    // edges and input halving
    logic src_d_reg;
    logic fb_d_reg;
    logic half_tog_reg;
    logic src_rise;
    logic fb_rise;
    logic eff_rise;

    assign src_rise = src_s & ~src_d_reg;
    assign fb_rise = fb_s & ~fb_d_reg;
    assign eff_rise = src_rise & (~act_half_reg | ~half_tog_reg);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            src_d_reg <= 1'b0;
            fb_d_reg <= 1'b0;
        end
        else
        begin
            src_d_reg <= src_s;
            fb_d_reg <= fb_s;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_tog_reg <= 1'b0;
        end
        else if (mgr_rst_reg)
        begin
            half_tog_reg <= 1'b0;
        end
        else if (src_rise)
        begin
            half_tog_reg <= ~half_tog_reg;
        end
    end

    // state and period measurement
    csl_pkg::csl_state_t state_reg;
    logic [15:0] cnt_reg;
    logic [15:0] period_reg;
    logic [15:0] new_period;
    logic cnt_sat;

    assign new_period = cnt_reg + 16'h0001;
    assign cnt_sat = (cnt_reg == csl_pkg::CSL_CNT_MAX);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= csl_pkg::CSL_ST_RESET;
        end
        else if (mgr_rst_reg)
        begin
            state_reg <= csl_pkg::CSL_ST_RESET;
        end
        else
        begin
            unique case (state_reg)
                csl_pkg::CSL_ST_RESET: state_reg <= csl_pkg::CSL_ST_WAIT;
                csl_pkg::CSL_ST_WAIT: if (eff_rise) state_reg <= csl_pkg::CSL_ST_MEAS;
                csl_pkg::CSL_ST_MEAS: if (eff_rise) state_reg <= csl_pkg::CSL_ST_RUN;
                // a vanished source clock drops back to waiting
                csl_pkg::CSL_ST_RUN: if (cnt_sat) state_reg <= csl_pkg::CSL_ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 16'h0000;
            period_reg <= 16'h0000;
        end
        else if (mgr_rst_reg)
        begin
            cnt_reg <= 16'h0000;
            period_reg <= 16'h0000;
        end
        else if (eff_rise)
        begin
            cnt_reg <= 16'h0000;
            if (state_reg != csl_pkg::CSL_ST_WAIT)
            begin
                period_reg <= new_period;
            end
        end
        else if (!cnt_sat)
        begin
            cnt_reg <= new_period;
        end
    end

    // feedback alignment: expected detection point depends on compensation
    logic [15:0] fb_expect;
    logic fb_aligned;
    logic fb_ok_reg;

    assign fb_expect = act_gclk_reg ? 16'h0000 : csl_pkg::CSL_SYNC_LAT;
    assign fb_aligned = fb_rise && (
        (cnt_reg >= fb_expect && (cnt_reg - fb_expect) <= csl_pkg::CSL_FB_TOL) ||
        (cnt_reg < fb_expect && (fb_expect - cnt_reg) <= csl_pkg::CSL_FB_TOL) ||
        (cnt_reg >= fb_expect && (period_reg + fb_expect - cnt_reg) <= csl_pkg::CSL_FB_TOL));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fb_ok_reg <= 1'b0;
        end
        else if (mgr_rst_reg)
        begin
            fb_ok_reg <= 1'b0;
        end
        else if (eff_rise)
        begin
            // an aligned edge in the clearing cycle counts for the next period
            fb_ok_reg <= fb_aligned;
        end
        else if (fb_aligned)
        begin
            fb_ok_reg <= 1'b1;
        end
    end

    // lock: enough consecutive stable periods, aligned when feedback is used
    logic [2:0] good_cnt_reg;
    logic locked_reg;
    logic period_good;

    assign period_good = ((new_period >= period_reg) ? (new_period - period_reg)
                         : (period_reg - new_period)) <= csl_pkg::CSL_PERIOD_TOL;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            good_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
        end
        else if (mgr_rst_reg || state_reg != csl_pkg::CSL_ST_RUN || cnt_sat)
        begin
            good_cnt_reg <= 3'h0;
            locked_reg <= 1'b0;
        end
        else if (eff_rise)
        begin
            if (period_good && (fb_ok_reg || fb_aligned || !act_fb_reg))
            begin
                if (good_cnt_reg != csl_pkg::CSL_LOCK_PERIODS)
                begin
                    good_cnt_reg <= good_cnt_reg + 3'h1;
                end
                locked_reg <= (good_cnt_reg + 3'h1 >= csl_pkg::CSL_LOCK_PERIODS);
            end
            else
            begin
                good_cnt_reg <= 3'h0;
                locked_reg <= 1'b0;
            end
        end
    end

    // base clock rebuilt from the true phase; compensation puts its edge at
    // the pad edge instead of after the synchronizer delay
    logic [15:0] true_phase;
    logic [15:0] wrap_phase;
    logic base_int_reg;
    logic base_int_next;
    logic base_rise;
    logic running;

    assign running = (state_reg == csl_pkg::CSL_ST_RUN) && !mgr_rst_reg && !cnt_sat;
    assign true_phase = cnt_reg + (act_gclk_reg ? csl_pkg::CSL_SYNC_LAT : 16'h0000);
    assign wrap_phase = (true_phase >= period_reg) ? (true_phase - period_reg) : true_phase;
    assign base_int_next = running && (wrap_phase < {1'b0, period_reg[15:1]});
    assign base_rise = base_int_next & ~base_int_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_int_reg <= 1'b0;
            base_clk_out <= 1'b0;
        end
        else
        begin
            base_int_reg <= base_int_next;
            base_clk_out <= base_int_next & act_fb_reg;
        end
    end

    // synthesizer: accumulate 2M per cycle, toggle each D*P, so the output
    // runs at M/(D*P) of clk_sys
    logic [5:0] div_cnt_reg;
    logic [23:0] acc_reg;
    logic [24:0] acc_sum;
    logic [23:0] acc_limit;
    logic synth_int_next;
    logic [23:0] acc_next;
    logic realign;

    // widen before the product: D*P needs up to 21 bits
    assign acc_limit = 24'(act_div_reg) * 24'(period_reg);
    assign acc_sum = {1'b0, acc_reg} + {18'h0_0000, act_mult_reg, 1'b0};
    assign realign = base_rise && (div_cnt_reg == 6'h00) && act_fb_reg;

    always_comb
    begin
        acc_next = acc_sum[23:0];
        synth_int_next = synth_clk_out;
        if (!running)
        begin
            acc_next = 24'h00_0000;
            synth_int_next = 1'b0;
        end
        else if (realign)
        begin
            acc_next = 24'h00_0000;
            synth_int_next = 1'b1;
        end
        else if (acc_sum >= {1'b0, acc_limit})
        begin
            acc_next = 24'(acc_sum - {1'b0, acc_limit});
            synth_int_next = ~synth_clk_out;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_reg <= 6'h00;
        end
        else if (!running)
        begin
            div_cnt_reg <= 6'h00;
        end
        else if (base_rise)
        begin
            div_cnt_reg <= (div_cnt_reg + 6'h01 >= act_div_reg) ? 6'h00
                : div_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= 24'h00_0000;
            synth_clk_out <= 1'b0;
            synth_clk_inv_out <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            synth_clk_out <= synth_int_next;
            synth_clk_inv_out <= running & ~synth_int_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            locked_out <= 1'b0;
        end
        else
        begin
            locked_out <= locked_reg & ~mgr_rst_reg;
        end
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[csl_pkg::CSL_LOCKED_BIT] = locked_out;
        status_word[csl_pkg::CSL_IN_RST_BIT] = mgr_rst_reg;
        status_word[csl_pkg::CSL_PVALID_BIT] = (state_reg == csl_pkg::CSL_ST_RUN);
        status_word[csl_pkg::CSL_PERIOD_LSB +: csl_pkg::CSL_PERIOD_W] = period_reg;
    end

    sequence s_reset_release;
        $fell(mgr_rst_reg) ##1 !locked_out;
    endsequence

    a_reset_clears_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mgr_rst_reg |=> ##1 (!locked_out && !synth_clk_out && !synth_clk_inv_out
        && !base_clk_out))
        else $error("outputs not low under manager reset");
    a_lock_after_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(mgr_rst_reg) |-> s_reset_release ##1 !locked_out)
        else $error("lock raised too soon after reset release");
    a_lock_needs_good: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(locked_reg) |-> good_cnt_reg == csl_pkg::CSL_LOCK_PERIODS)
        else $error("lock raised before enough stable periods");
    a_inv_twin: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(running) |-> synth_clk_inv_out == !synth_clk_out)
        else $error("inverted output not opposite to synthesized output");
    a_no_halving: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!act_half_reg && src_rise) |-> eff_rise)
        else $error("source edge lost without halving");
    // a source period of at least four cycles puts halved edges eight apart
    a_halving_skip: assert property (@(posedge clk_sys)
        disable iff (!rst_n || mgr_rst_reg)
        (act_half_reg && eff_rise) |=> !eff_rise [*7])
        else $error("halving passed two consecutive source edges");
    a_realign_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (running && realign) |=> (synth_clk_out && acc_reg == 24'h00_0000))
        else $error("synthesized output not realigned at base edge");
    a_start_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_reg == csl_pkg::CSL_ST_WAIT && eff_rise && !mgr_rst_reg)
        |=> state_reg == csl_pkg::CSL_ST_MEAS)
        else $error("locking did not start at first source edge");
    a_base_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !act_fb_reg |=> !base_clk_out)
        else $error("base output driven without feedback");
    a_freeze_setting: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!mgr_rst_reg && !$past(mgr_rst_reg)) |->
        ($stable(act_mult_reg) && $stable(act_div_reg)))
        else $error("settings changed outside reset");

endmodule : csl_clock_synth_lock_reset

`default_nettype wire

//--- tb/csl_partner.sv
/*
  csl_partner: source clock pin driver and global-buffer feedback return.
  Assumes it shares clk_sys with the block; half period is in clk_sys cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module csl_partner (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [7:0] half,
    input wire logic base_clk_out,
    output logic source_clk_in,
    output logic feedback_clk_in
);
    logic [7:0] cnt_reg = 8'h00;

    initial source_clk_in = 1'b0;
    initial feedback_clk_in = 1'b0;

    // clock stands low when not running; it models a global input buffer path
    always @(posedge clk_sys)
    begin
        if (!run)
        begin
            cnt_reg <= 8'h00;
            source_clk_in <= 1'b0;
        end
        else if (cnt_reg == half - 8'h01)
        begin
            cnt_reg <= 8'h00;
            source_clk_in <= !source_clk_in;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // only the base output returns, one buffer cycle late
    always @(posedge clk_sys)
    begin
        feedback_clk_in <= base_clk_out;
    end
endmodule : csl_partner

`default_nettype wire

//--- tb/csl_clock_synth_lock_reset_bench.sv
/*
  csl_clock_synth_lock_reset_bench: scenario tasks for lock, reset, halving
  and no-feedback mode. Assumes csl_pkg and csl_partner are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module csl_clock_synth_lock_reset_bench;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic source_clk_in;
    logic feedback_clk_in;
    logic manager_reset_in = 1'b1;
    logic global_set_reset = 1'b1;
    logic synth_clk_out;
    logic synth_clk_inv_out;
    logic base_clk_out;
    logic locked_out;
    logic run = 1'b0;
    logic [7:0] half = 8'h0A;
    logic [31:0] rd;
    int err_total = 0;
    int n_checks = 0;
    int n_syn;
    int n_base;
    int n_bad;
    int n_mis;
    int n_hi;
    int n_ph;

    csl_clock_synth_lock_reset u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_clk_in(source_clk_in),
        .feedback_clk_in(feedback_clk_in), .manager_reset_in(manager_reset_in),
        .global_set_reset(global_set_reset), .synth_clk_out(synth_clk_out),
        .synth_clk_inv_out(synth_clk_inv_out), .base_clk_out(base_clk_out),
        .locked_out(locked_out)
    );

    csl_partner u_far (
        .clk_sys(clk_sys), .run(run), .half(half), .base_clk_out(base_clk_out),
        .source_clk_in(source_clk_in), .feedback_clk_in(feedback_clk_in)
    );

    initial
    begin
        forever #50 clk_sys = !clk_sys;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // count within one edge, since the window start falls at an arbitrary phase
    task automatic near(input string what, input int seen, input int exp);
        check(what, {31'h0, (seen >= exp - 1 && seen <= exp + 1)}, 32'h1);
    endtask : near

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
        if (n >= 20)
        begin
            err_total++;
            test_done();
        end
    endtask : wb

    task automatic wait_lock(output int n);
        n = 0;
        while (locked_out !== 1'b1 && n < 4000)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 4000)
        begin
            err_total++;
            test_done();
        end
    endtask : wait_lock

    task automatic watch(input int cycles);
        logic ps;
        logic pb;
        logic [1:0] sh;
        ps = synth_clk_out;
        pb = base_clk_out;
        sh = 2'b11;
        n_syn = 0;
        n_base = 0;
        n_bad = 0;
        n_mis = 0;
        n_hi = 0;
        n_ph = 0;
        repeat (cycles)
        begin
            @(negedge clk_sys);
            n_syn += (synth_clk_out && !ps);
            n_base += (base_clk_out && !pb);
            n_mis += (base_clk_out && !pb && !(synth_clk_out && !ps));
            // a compensated base edge trails the pad edge by one register stage
            n_ph += (base_clk_out && !pb && sh != 2'b01);
            n_bad += (synth_clk_inv_out !== !synth_clk_out);
            n_hi += ((synth_clk_out | synth_clk_inv_out | base_clk_out | locked_out) !== 1'b0);
            ps = synth_clk_out;
            pb = base_clk_out;
            sh = {sh[0], source_clk_in};
        end
    endtask : watch

    task automatic start_mgr(input logic [7:0] h, input logic [31:0] ctrl, output int n);
        manager_reset_in <= 1'b1;
        half <= h;
        wb(1'b1, csl_pkg::CSL_CTRL_ADDR, ctrl);
        wb(1'b0, csl_pkg::CSL_CTRL_ADDR, 32'h0000_0000);
        check("ctrl readback", rd, ctrl);
        repeat (8 * h) @(posedge clk_sys);
        manager_reset_in <= 1'b0;
        wait_lock(n);
    endtask : start_mgr

    task automatic t_regs;
        wb(1'b0, csl_pkg::CSL_CTRL_ADDR, 32'h0000_0000);
        check("ctrl reset", rd, csl_pkg::CSL_CTRL_RST);
        wb(1'b0, 8'h08, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        wb(1'b0, csl_pkg::CSL_STATUS_ADDR, 32'h0000_0000);
        check("status in reset", rd[1:0], 2'b10);
        $display("test regs done");
    endtask : t_regs

    task automatic t_lock_1x;
        int n;
        global_set_reset <= 1'b0;
        start_mgr(8'h0A, 32'h0006_0104, n);
        check("lock late enough", {31'h0, n >= 100}, 32'h1);
        wb(1'b0, csl_pkg::CSL_STATUS_ADDR, 32'h0000_0000);
        check("period", rd[31:16], 16'h0014);
        check("locked status", rd[2:0], 3'b101);
        watch(200);
        near("synth edges", n_syn, 40);
        near("base edges", n_base, 10);
        check("inverted twin", n_bad, 0);
        check("synth on base edge", n_mis, 0);
        check("base at pad edge", n_ph, 0);
        $display("test lock 1x done");
    endtask : t_lock_1x

    task automatic t_reset;
        manager_reset_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        watch(40);
        check("outputs low in reset", n_hi, 0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_halve;
        int n;
        start_mgr(8'h0A, 32'h0007_0203, n);
        wb(1'b0, csl_pkg::CSL_STATUS_ADDR, 32'h0000_0000);
        check("halved period", rd[31:16], 16'h0028);
        watch(400);
        near("synth 3/2 edges", n_syn, 15);
        near("base halved edges", n_base, 10);
        near("realign once per divisor", n_mis, 5);
        check("inverted twin halved", n_bad, 0);
        $display("test halve done");
    endtask : t_halve

    task automatic t_none;
        int n;
        global_set_reset <= 1'b1;
        manager_reset_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        wb(1'b0, csl_pkg::CSL_STATUS_ADDR, 32'h0000_0000);
        check("held by global reset", rd[1:0], 2'b10);
        global_set_reset <= 1'b0;
        start_mgr(8'h0A, 32'h0000_0104, n);
        watch(200);
        check("base idle", n_base, 0);
        near("synth edges none", n_syn, 40);
        check("inverted twin none", n_bad, 0);
        $display("test none done");
    endtask : t_none

    initial
    begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        run <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_lock_1x();
        t_reset();
        t_halve();
        t_none();
        test_done();
    end
endmodule : csl_clock_synth_lock_reset_bench

`default_nettype wire
